//--- verilog/dsc_consts.svh
/*
 Constants of the dual converter serial command port: frame layout,
 channel select codes, power-on codes and reset values.
 Assumes inclusion by bare name from the port's design files.
*/
`ifndef DSC_CONSTS_SVH
`define DSC_CONSTS_SVH

// ====================================================================
// Frame layout
`define DSC_FRAME_BITS  32
`define DSC_MSB         31
`define DSC_CMD_HI      27
`define DSC_CMD_LO      24
`define DSC_ADDR_HI     23
`define DSC_ADDR_LO     20
`define DSC_DATA_HI     19
`define DSC_DATA_LO     4
`define DSC_DATA_W      16
`define DSC_CHAIN_BIT   1
`define DSC_CNT_W       5
`define DSC_CNT_LAST    5'h1F
`define DSC_CNT_FIRST   5'h01

// ====================================================================
// Channel select codes
`define DSC_ADDR_A      4'h0
`define DSC_ADDR_B      4'h3
`define DSC_ADDR_BOTH   4'hF
`define DSC_NUM_CH      2

// ====================================================================
// Power-on codes and reset values
`define DSC_CODE_ZERO   16'h0000
`define DSC_CODE_MID    16'h8000
`define DSC_CHAIN_RST   1'b0

`endif

//--- verilog/dsc_pkg.sv
/*
 Types of the dual converter serial command port.
 Assumes nothing of its surroundings.
*/
package dsc_pkg;

   // =================================================================
   // Command field encodings
   typedef enum logic [3:0] {
      DSC_CMD_WR_IN    = 4'h0,
      DSC_CMD_UPD_OUT  = 4'h1,
      DSC_CMD_WR_ALL   = 4'h2,
      DSC_CMD_WR_UPD   = 4'h3,
      DSC_CMD_PWR      = 4'h4,
      DSC_CMD_CLR_CODE = 4'h5,
      DSC_CMD_LOAD_CTL = 4'h6,
      DSC_CMD_SW_RST   = 4'h7,
      DSC_CMD_CHAIN    = 4'h8
   } dsc_cmd_e;

   typedef logic [15:0] dsc_code_t;

endpackage

//--- verilog/dsc_sync.sv
/*
 Two-flop level synchroniser.
 Assumes d is a level from another domain; arst is a constant-tied or
 domain-local asynchronous clear.
*/
`timescale 1ns/1ps

module dsc_sync (
   // Clock and clear
   input  wire logic clk,
   input  wire logic arst,
   // Level in and out
   input  wire logic d,
   output logic      q
);

   logic meta_r;

   // =================================================================
   // Stages; first stage read by second only
   always_ff @(posedge clk or posedge arst) begin
      if (arst) begin
         meta_r <= 1'b0;
         q      <= 1'b0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end

endmodule

//--- verilog/dsc_chan.sv
/*
 One converter channel: input register and output register.
 Assumes wr, upd and init are synchronous to clk; upd and init may stay high.
*/
`timescale 1ns/1ps
`include "dsc_consts.svh"

module dsc_chan (
   // Clock
   input  wire logic                     clk,
   // Control
   input  wire logic                     init,
   input  wire logic                     wr,
   input  wire logic                     upd,
   // Data
   input  wire dsc_pkg::dsc_code_t       init_code,
   input  wire dsc_pkg::dsc_code_t       data,
   output dsc_pkg::dsc_code_t            out_code
);

   dsc_pkg::dsc_code_t in_r;

   // =================================================================
   // Input register
   always_ff @(posedge clk) begin
      if (init) begin
         in_r <= init_code;
      end else if (wr) begin
         in_r <= data;
      end
   end

   // =================================================================
   // Output register; a write with update goes straight through
   always_ff @(posedge clk) begin
      if (init) begin
         out_code <= init_code;
      end else if (upd) begin
         out_code <= wr ? data : in_r;
      end
   end

endmodule

//--- verilog/dsc_port.sv
/*
 Serial command port of a dual converter: shift register on the
 serial clock, command decode and channel registers on ref_clk.
 Assumes the host keeps its framing and clock-rate obligations and
 that the serial clock is idle while srst is released.
*/
`timescale 1ns/1ps
`include "dsc_consts.svh"

// Function
// - Frame is 32 bits MSB first: pad, command, channel select, data.
// - Data field carries 16-bit code followed by four bits, ignored except bit 1 for command 1000.
// - Select 0000 is A, 0011 is B, 1111 both; others none.
// - Commands 0-3 write input, update output, write-all, write-update.
// - Commands 4-6 decoded without effect; 9 to 15 do nothing.
// - Command 0111 resets channels to pin-chosen power-on code.
// - Command 1000 sets chain mode from data bit 1; default standalone.
// - Falling strobe opens frame; data sampled on falling serial clock.
// - On 32nd falling edge the decoded command executes; in chain mode at strobe rise.
// - Strobe rising before 32 edges voids frame, nothing executes.
// - Chain mode shifts old bits out, changing on rising edges.
// - Chained frame not a multiple of 32 clocks is discarded.
// - Clock and data ignored while strobe is high.
// - Reset gives zero scale when pin low, midscale when high.
// - Outputs hold power-on code until a valid frame executes.
// - Load strobe low copies input to output, also on writes.
module dsc_port (
   // Clock and reset
   input  wire logic               ref_clk,
   input  wire logic               srst,
   // Serial link
   input  wire logic               serial_clk,
   input  wire logic               frame_strobe_n,
   input  wire logic               serial_data_in,
   output logic                    serial_data_out,
   // Pins
   input  wire logic               load_strobe_n,
   input  wire logic               por_level,
   // Status
   output dsc_pkg::dsc_code_t      out_code_a,
   output dsc_pkg::dsc_code_t      out_code_b,
   output logic                    chain_enable,
   output logic                    cmd_exec
);

   // =================================================================
   // Declarations
   logic [`DSC_MSB:0]    shift_r;
   logic [`DSC_CNT_W-1:0] cnt_r;
   logic                 fresh_r;
   logic                 seen32_r;
   logic                 done_r;
   logic                 chain_ok_r;
   logic                 link_rst_r;
   logic                 chain_l;
   logic                 serial_clk_n;
   logic                 frame_s;
   logic                 frame_d_r;
   logic                 done_s;
   logic                 done_d_r;
   logic                 ok_s;
   logic                 load_s;
   logic                 por_s;
   logic                 exec_nxt;
   logic [`DSC_MSB:0]    word_r;
   logic [3:0]           addr_w;
   dsc_pkg::dsc_cmd_e    cmd_w;
   dsc_pkg::dsc_code_t   data_w;
   dsc_pkg::dsc_code_t   init_code;
   logic                 init_w;
   logic                 wr_cmd;
   logic                 upd_cmd;
   logic                 all_cmd;
   logic                 chain_cmd;
   dsc_pkg::dsc_code_t   code_w [`DSC_NUM_CH];

   assign serial_clk_n = ~serial_clk;

   // =================================================================
   // Link reset
   // Held from ref domain; the serial clock is idle across release
   always_ff @(posedge ref_clk) begin
      link_rst_r <= srst;
   end

   // =================================================================
   // Chain mode into the link domain
   // Mode only changes between frames, so two edges of delay is safe
   dsc_sync u_sync_chain (
      .clk  (serial_clk_n),
      .arst (link_rst_r),
      .d    (chain_enable),
      .q    (chain_l)
   );

   // =================================================================
   // Frame start marker, set by the strobe itself
   always_ff @(negedge serial_clk or posedge frame_strobe_n) begin
      if (frame_strobe_n) begin
         fresh_r <= 1'b1;
      end else begin
         fresh_r <= 1'b0;
      end
   end

   // =================================================================
   // Shift register and bit count
   always_ff @(negedge serial_clk or posedge link_rst_r) begin
      if (link_rst_r) begin
         shift_r    <= '0;
         cnt_r      <= '0;
         seen32_r   <= 1'b0;
         done_r     <= 1'b0;
         chain_ok_r <= 1'b0;
      end else if (!frame_strobe_n) begin
         if (fresh_r) begin
            // New frame starts from a cleared register
            shift_r    <= {{`DSC_MSB{1'b0}}, serial_data_in};
            cnt_r      <= `DSC_CNT_FIRST;
            seen32_r   <= 1'b0;
            done_r     <= 1'b0;
            chain_ok_r <= 1'b0;
         end else if (chain_l || !seen32_r) begin
            shift_r    <= {shift_r[`DSC_MSB-1:0], serial_data_in};
            cnt_r      <= `DSC_CNT_W'(cnt_r + `DSC_CNT_FIRST);
            chain_ok_r <= chain_l && (cnt_r == `DSC_CNT_LAST);
            if (cnt_r == `DSC_CNT_LAST) begin
               seen32_r <= 1'b1;
               done_r   <= !chain_l;
            end
         end
      end
   end

   // =================================================================
   // Serial output, changes on rising edges
   always_ff @(posedge serial_clk or posedge link_rst_r) begin
      if (link_rst_r) begin
         serial_data_out <= 1'b0;
      end else begin
         serial_data_out <= chain_l & shift_r[`DSC_MSB];
      end
   end

   // =================================================================
   // Crossings into the ref domain
   dsc_sync u_sync_frame (
      .clk  (ref_clk),
      .arst (1'b0),
      .d    (frame_strobe_n),
      .q    (frame_s)
   );

   dsc_sync u_sync_done (
      .clk  (ref_clk),
      .arst (1'b0),
      .d    (done_r),
      .q    (done_s)
   );

   dsc_sync u_sync_ok (
      .clk  (ref_clk),
      .arst (1'b0),
      .d    (chain_ok_r),
      .q    (ok_s)
   );

   dsc_sync u_sync_load (
      .clk  (ref_clk),
      .arst (1'b0),
      .d    (load_strobe_n),
      .q    (load_s)
   );

   dsc_sync u_sync_por (
      .clk  (ref_clk),
      .arst (1'b0),
      .d    (por_level),
      .q    (por_s)
   );

   // =================================================================
   // Execute strobe
   // The word is stable here: the link is idle until the next frame
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         frame_d_r <= 1'b1;
         done_d_r  <= 1'b0;
      end else begin
         frame_d_r <= frame_s;
         done_d_r  <= done_s;
      end
   end

   // Standalone acts at bit 32, chain mode at strobe rise
   assign exec_nxt = (done_s & ~done_d_r & ~chain_enable)
                   | (frame_s & ~frame_d_r & chain_enable & ok_s);

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         cmd_exec <= 1'b0;
         word_r   <= '0;
      end else begin
         cmd_exec <= exec_nxt;
         if (exec_nxt) begin
            word_r <= shift_r;
         end
      end
   end

   // =================================================================
   // Field decode
   assign cmd_w  = dsc_pkg::dsc_cmd_e'(word_r[`DSC_CMD_HI:`DSC_CMD_LO]);
   assign addr_w = word_r[`DSC_ADDR_HI:`DSC_ADDR_LO];
   assign data_w = word_r[`DSC_DATA_HI:`DSC_DATA_LO];

   always_comb begin
      wr_cmd    = 1'b0;
      upd_cmd   = 1'b0;
      all_cmd   = 1'b0;
      chain_cmd = 1'b0;
      init_w    = srst;
      case (cmd_w)
         dsc_pkg::DSC_CMD_WR_IN: begin
            wr_cmd = cmd_exec;
         end
         dsc_pkg::DSC_CMD_UPD_OUT: begin
            upd_cmd = cmd_exec;
         end
         dsc_pkg::DSC_CMD_WR_ALL: begin
            wr_cmd  = cmd_exec;
            all_cmd = cmd_exec;
         end
         dsc_pkg::DSC_CMD_WR_UPD: begin
            wr_cmd  = cmd_exec;
            upd_cmd = cmd_exec;
         end
         dsc_pkg::DSC_CMD_SW_RST: begin
            init_w = srst | cmd_exec;
         end
         dsc_pkg::DSC_CMD_CHAIN: begin
            chain_cmd = cmd_exec;
         end
         default: begin
            // Power, clear code and load control have no effect here
            wr_cmd = 1'b0;
         end
      endcase
   end

   // Pin level chosen at reset and on software reset
   assign init_code = por_s ? `DSC_CODE_MID : `DSC_CODE_ZERO;

   // =================================================================
   // Chain enable register
   always_ff @(posedge ref_clk) begin
      if (init_w) begin
         chain_enable <= `DSC_CHAIN_RST;
      end else if (chain_cmd) begin
         chain_enable <= word_r[`DSC_CHAIN_BIT];
      end
   end

   // =================================================================
   // Channels
   genvar gi;
   generate
      for (gi = 0; gi < `DSC_NUM_CH; gi = gi + 1) begin : g_ch
         logic sel;
         assign sel = (addr_w == ((gi == 0) ? `DSC_ADDR_A : `DSC_ADDR_B))
                    || (addr_w == `DSC_ADDR_BOTH);
         dsc_chan u_chan (
            .clk       (ref_clk),
            .init      (init_w),
            .wr        (wr_cmd & sel),
            .upd       ((upd_cmd & sel) | all_cmd | ~load_s),
            .init_code (init_code),
            .data      (data_w),
            .out_code  (code_w[gi])
         );
      end
   endgenerate

   assign out_code_a = code_w[0];
   assign out_code_b = code_w[1];

   // =================================================================
   // Checks on the link side
   AST_SDO_QUIET: assert property (
      @(posedge serial_clk) disable iff (link_rst_r)
      !chain_l |=> !serial_data_out)
      else $error("serial output active in standalone mode");

   AST_IGNORE_HIGH: assert property (
      @(negedge serial_clk) disable iff (link_rst_r)
      frame_strobe_n |=> $stable(shift_r))
      else $error("shift register moved while strobe high");

   AST_MSB_FIRST: assert property (
      @(negedge serial_clk) disable iff (link_rst_r)
      (!frame_strobe_n && !fresh_r && (chain_l || !seen32_r))
      |=> (shift_r[`DSC_MSB:1] == $past(shift_r[`DSC_MSB-1:0]))
       && (shift_r[0] == $past(serial_data_in)))
      else $error("shift not msb first");

   AST_STOP_AT_32: assert property (
      @(negedge serial_clk) disable iff (link_rst_r)
      (!frame_strobe_n && !fresh_r && !chain_l
       && (cnt_r == `DSC_CNT_LAST)) |=> done_r)
      else $error("frame not complete after 32 bits");

   // =================================================================
   // Checks on the ref side
   AST_EXEC_AT_32: assert property (
      @(posedge ref_clk) disable iff (srst)
      (done_s && !done_d_r && !chain_enable) |=> cmd_exec)
      else $error("complete frame did not execute");

   AST_ABORT: assert property (
      @(posedge ref_clk) disable iff (srst)
      (cmd_exec && !$past(chain_enable))
      |-> ($past(done_s) && !$past(done_s, 2)))
      else $error("execute without a complete frame");

   AST_CHAIN_FRAME: assert property (
      @(posedge ref_clk) disable iff (srst)
      (cmd_exec && $past(chain_enable)) |-> $past(ok_s))
      else $error("chained frame executed at a bad count");

   AST_RES_SEL: assert property (
      @(posedge ref_clk) disable iff (srst)
      (cmd_exec && load_s && !all_cmd && !init_w
       && (addr_w != `DSC_ADDR_A)
       && (addr_w != `DSC_ADDR_B) && (addr_w != `DSC_ADDR_BOTH))
      |=> $stable(out_code_a) && $stable(out_code_b))
      else $error("reserved select changed an output");

   AST_RES_CMD: assert property (
      @(posedge ref_clk) disable iff (srst)
      (cmd_exec && load_s && (word_r[`DSC_CMD_HI:`DSC_CMD_LO] > 4'h8))
      |=> $stable(out_code_a) && $stable(out_code_b)
       && $stable(chain_enable))
      else $error("reserved command had an effect");

   AST_SW_RESET: assert property (
      @(posedge ref_clk) disable iff (srst)
      (cmd_exec && (cmd_w == dsc_pkg::DSC_CMD_SW_RST))
      |=> (out_code_a == $past(init_code))
       && (out_code_b == $past(init_code)) && !chain_enable)
      else $error("software reset did not restore power-on state");

   AST_CHAIN_WRITE: assert property (
      @(posedge ref_clk) disable iff (srst)
      (cmd_exec && (cmd_w == dsc_pkg::DSC_CMD_CHAIN))
      |=> chain_enable == $past(word_r[`DSC_CHAIN_BIT]))
      else $error("chain enable not written from data bit 1");

   AST_WRITE_ALL: assert property (
      @(posedge ref_clk) disable iff (srst)
      (cmd_exec && (cmd_w == dsc_pkg::DSC_CMD_WR_ALL)
       && ((addr_w == `DSC_ADDR_A) || (addr_w == `DSC_ADDR_BOTH)))
      |=> out_code_a == $past(data_w))
      else $error("write and update all missed channel a");

   AST_WRITE_HOLD: assert property (
      @(posedge ref_clk) disable iff (srst)
      (cmd_exec && load_s && (cmd_w == dsc_pkg::DSC_CMD_WR_IN))
      |=> $stable(out_code_a) && $stable(out_code_b))
      else $error("input write reached an output");

   AST_POR_CODE: assert property (
      @(posedge ref_clk)
      $fell(srst) |-> (out_code_a == $past(init_code))
                   && (out_code_b == $past(init_code)))
      else $error("reset code does not follow level pin");

   AST_HOLD_IDLE: assert property (
      @(posedge ref_clk) disable iff (srst)
      (!cmd_exec && load_s) |=> $stable(out_code_a) && $stable(out_code_b))
      else $error("output moved without a frame or load");

   AST_LOAD_LOW: assert property (
      @(posedge ref_clk) disable iff (srst)
      (!load_s && !cmd_exec) [*2]
      |=> out_code_a == $past(g_ch[0].u_chan.in_r))
      else $error("output not following input while load low");

endmodule

//--- dv/dsc_host.sv
/*
 Host master model for the serial command port: frames, aborted frames
 and stray clocks while the strobe is high.
 Assumes the caller spaces frames by calling send; echo_bits keeps the
 chain output sampled at each falling serial clock of a send.
*/
`timescale 1ns/1ps

module dsc_host (
   // Serial link toward the port
   output logic      serial_clk,
   output logic      frame_strobe_n,
   output logic      serial_data_in,
   // Chain output of the port
   input  wire logic serial_data_out
);
   logic [63:0] echo_bits;

   initial begin
      serial_clk = 1'b1;
      frame_strobe_n = 1'b1;
      serial_data_in = 1'b0;
      echo_bits = '0;
   end

   // ==================================================================
   // Frame: n bits from w[63] down, 15 ns clock, then idle gap
   task automatic send(input logic [63:0] w, input int n);
      frame_strobe_n = 1'b0;
      #10.0;
      for (int i = 63; i > 63 - n; i--) begin
         serial_data_in = w[i];
         #7.5;
         echo_bits = {echo_bits[62:0], serial_data_out};
         serial_clk = 1'b0;
         #7.5;
         serial_clk = 1'b1;
      end
      #5.0;
      frame_strobe_n = 1'b1;
      // Released line shows the inverse so stale data never looks valid
      serial_data_in = ~serial_data_in;
      #1900.0;
   endtask

   // ==================================================================
   // Stray clocks with the strobe high
   task automatic stray(input int n);
      for (int i = 0; i < n; i++) begin
         serial_data_in = ~serial_data_in;
         #7.5;
         serial_clk = 1'b0;
         #7.5;
         serial_clk = 1'b1;
      end
   endtask
endmodule

//--- dv/dsc_port_tb.sv
/*
 Self-checking bench of the serial command port: a queue of expected
 outputs per frame, checked when the port signals execution.
 Assumes dsc_pkg, dsc_consts.svh and dv/dsc_host.sv are compiled.
*/
`timescale 1ns/1ps
`include "dsc_consts.svh"

module dsc_port_tb;
   typedef struct packed {
      dsc_pkg::dsc_code_t a;
      dsc_pkg::dsc_code_t b;
      logic               ch;
   } dsc_note_s;

   logic               ref_clk;
   logic               srst;
   logic               load_strobe_n;
   logic               por_level;
   logic               serial_clk;
   logic               frame_strobe_n;
   logic               serial_data_in;
   logic               serial_data_out;
   dsc_pkg::dsc_code_t out_code_a;
   dsc_pkg::dsc_code_t out_code_b;
   logic               chain_enable;
   logic               cmd_exec;
   dsc_note_s          notes[$];
   dsc_note_s          mdl;
   dsc_pkg::dsc_code_t in_a;
   dsc_pkg::dsc_code_t in_b;
   logic [31:0]        rng;
   logic [31:0]        r;
   logic [3:0]         sel_tab [5] = '{4'h0, 4'h3, 4'hF, 4'h1, 4'h2};
   int                 fails;
   int                 compares;
   int                 cycles;

   dsc_port i_dsc_port (
      .ref_clk         (ref_clk),
      .srst            (srst),
      .serial_clk      (serial_clk),
      .frame_strobe_n  (frame_strobe_n),
      .serial_data_in  (serial_data_in),
      .serial_data_out (serial_data_out),
      .load_strobe_n   (load_strobe_n),
      .por_level       (por_level),
      .out_code_a      (out_code_a),
      .out_code_b      (out_code_b),
      .chain_enable    (chain_enable),
      .cmd_exec        (cmd_exec)
   );

   dsc_host i_dsc_host (
      .serial_clk      (serial_clk),
      .frame_strobe_n  (frame_strobe_n),
      .serial_data_in  (serial_data_in),
      .serial_data_out (serial_data_out)
   );

   // ==================================================================
   // Helpers
   function automatic logic [31:0] rnd();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic cmp(input dsc_note_s n);
      check("out_code_a", {16'h0, out_code_a}, {16'h0, n.a});
      check("out_code_b", {16'h0, out_code_b}, {16'h0, n.b});
      check("chain_enable", {31'h0, chain_enable}, {31'h0, n.ch});
   endtask

   function automatic logic [31:0] mk(input logic [3:0] cmd,
      input logic [3:0] sel, input logic [15:0] d, input logic [3:0] lo);
      logic [31:0] t;
      t = rnd();
      return {t[31:28], cmd, sel, d, lo};
   endfunction

   // Expected effect of one executed frame
   task automatic note(input logic [3:0] cmd, input logic [3:0] sel,
                       input logic [15:0] d, input logic [3:0] lo);
      logic               sa;
      logic               sb;
      dsc_pkg::dsc_code_t pc;
      sa = (sel == `DSC_ADDR_A) || (sel == `DSC_ADDR_BOTH);
      sb = (sel == `DSC_ADDR_B) || (sel == `DSC_ADDR_BOTH);
      pc = por_level ? `DSC_CODE_MID : `DSC_CODE_ZERO;
      if (cmd inside {4'h0, 4'h2, 4'h3}) begin
         if (sa) in_a = d;
         if (sb) in_b = d;
      end
      if ((cmd == 4'h1 || cmd == 4'h3) && sa) mdl.a = in_a;
      if ((cmd == 4'h1 || cmd == 4'h3) && sb) mdl.b = in_b;
      if (cmd == 4'h2) begin
         mdl.a = in_a;
         mdl.b = in_b;
      end
      if (cmd == 4'h7) begin
         in_a = pc;
         in_b = pc;
         mdl = '{pc, pc, 1'b0};
      end
      if (cmd == 4'h8) mdl.ch = lo[1];
      notes.push_back(mdl);
   endtask

   // Leftover note means a frame never executed
   task automatic flush();
      check("missing exec", 32'(notes.size()), 32'h0);
      if (notes.size() != 0) cmp(notes.pop_front());
   endtask

   task automatic frame(input logic [3:0] cmd, input logic [3:0] sel,
                        input logic [15:0] d, input logic [3:0] lo);
      note(cmd, sel, d, lo);
      i_dsc_host.send({mk(cmd, sel, d, lo), 32'h0}, 32);
      flush();
   endtask

   task automatic conclude();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // ==================================================================
   // Clock, timeout and watcher
   always #4 ref_clk = ~ref_clk;

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         conclude();
      end
   end

   always @(posedge ref_clk) begin
      #1;
      if (cmd_exec === 1'b1) begin
         @(posedge ref_clk);
         #1;
         if (notes.size() == 0) begin
            check("spurious exec", 32'h1, 32'h0);
         end else begin
            cmp(notes.pop_front());
         end
      end
   end

   // ==================================================================
   // Main sequence
   initial begin
      ref_clk = 1'b0;
      srst = 1'b1;
      load_strobe_n = 1'b1;
      por_level = 1'b1;
      rng = 32'h61B1;
      fails = 0;
      compares = 0;
      cycles = 0;
      repeat (20) @(posedge ref_clk);
      #1 srst = 1'b0;
      repeat (4) @(posedge ref_clk);
      #1 mdl = '{`DSC_CODE_MID, `DSC_CODE_MID, `DSC_CHAIN_RST};
      cmp(mdl);
      r = rnd();
      frame(4'h0, `DSC_ADDR_BOTH, r[15:0], r[3:0]);
      for (int c = 0; c < 16; c++) begin
         r = rnd();
         if (c != 7 && c != 8) frame(4'(c), sel_tab[c % 5], r[19:4], r[3:0]);
      end
      // Aborted frame leaves input and output registers alone
      i_dsc_host.send({mk(4'h3, `DSC_ADDR_A, ~in_a, 4'h0), 32'h0}, 20);
      cmp(mdl);
      frame(4'h1, `DSC_ADDR_A, 16'h0, 4'h0);
      i_dsc_host.stray(9);
      frame(4'h3, `DSC_ADDR_A, 16'hA5C3, 4'h0);
      // Load pin copies input registers to outputs
      frame(4'h0, `DSC_ADDR_BOTH, 16'h1234, 4'h0);
      @(posedge ref_clk);
      #1 load_strobe_n = 1'b0;
      repeat (6) @(posedge ref_clk);
      #1 load_strobe_n = 1'b1;
      mdl.a = in_a;
      mdl.b = in_b;
      cmp(mdl);
      // Chain mode: two words, the first one echoed out
      frame(4'h8, 4'h0, 16'h0, 4'h2);
      r = rnd();
      note(4'h3, `DSC_ADDR_B, r[19:4], 4'h0);
      i_dsc_host.send({r, mk(4'h3, `DSC_ADDR_B, r[19:4], 4'h0)}, 64);
      check("chain echo", i_dsc_host.echo_bits[31:0], r);
      flush();
      i_dsc_host.send({rnd(), rnd()}, 48);
      cmp(mdl);
      frame(4'h8, 4'h0, 16'h0, 4'h1);
      // Software reset to zero code
      @(posedge ref_clk);
      #1 por_level = 1'b0;
      repeat (4) @(posedge ref_clk);
      frame(4'h7, 4'h0, 16'hFFFF, 4'h0);
      conclude();
   end
endmodule
